// [hmc_holdover_mode_control.sv]
// Holdover mode control: control register, holdover source choice and readback
`timescale 1ns/10ps
`include "hmc_params.svh"
module hmc_holdover_mode_control #(
    parameter int ADDR_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [15:0] i_freq_low,
    input wire logic [18:0] i_dpll_freq,
    input wire hmc_pkg::hmc_avg_t i_avg,
    input wire logic i_manual_holdover,
    input wire logic i_full_holdover,
    input wire logic i_mini_holdover,
    output hmc_pkg::hmc_src_t o_freq_src,
    output logic [18:0] o_holdover_freq,
    output logic [18:0] o_freq_readback,
    output logic o_fast_sel,
    output logic o_in_holdover
);

    // Refused at elaboration: the control offset needs seven address bits
    if (ADDR_W < 7) begin
        $error("hmc_holdover_mode_control: ADDR_W too small for the control offset");
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    hmc_pkg::hmc_ctrl_t ctrl_r;
    logic in_hold_d_r;
    logic [18:0] frozen_q;

    wire ctrl_hit = (i_reg_addr == ADDR_W'(`HMC_ADDR_HOLD_CTRL));
    wire ctrl_wr = i_reg_wr && ctrl_hit;
    wire ctrl_rd = i_reg_rd && ctrl_hit;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= hmc_pkg::hmc_ctrl_t'(`HMC_CTRL_RST);
        end else if (ctrl_wr) begin
            ctrl_r <= hmc_pkg::hmc_ctrl_t'(i_reg_wdata);
        end
    end

    // ------------------------------------------------------------------------
    // Frequency words
    // ------------------------------------------------------------------------
    wire [18:0] manual_word = {ctrl_r.freq_hi, i_freq_low};
    wire [18:0] avg_word = ctrl_r.fast_avg ? i_avg.fast : i_avg.slow;
    // Readback either mirrors software's word or exposes the averager
    wire [18:0] readback_nxt = ctrl_r.read_avg ? avg_word : manual_word;

    // ------------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------------
    wire in_hold = i_full_holdover || i_mini_holdover;
    wire hold_entry = in_hold && !in_hold_d_r;
    wire hmc_pkg::hmc_src_t avg_src = ctrl_r.fast_avg ? hmc_pkg::HMC_SRC_FAST
                                                       : hmc_pkg::HMC_SRC_SLOW;
    // Manual control overrides the averaging enable
    wire hmc_pkg::hmc_src_t full_src = i_manual_holdover ? hmc_pkg::HMC_SRC_MANUAL
                                     : ctrl_r.auto_avg ? avg_src
                                     : hmc_pkg::HMC_SRC_FROZEN;
    hmc_pkg::hmc_src_t mini_src;
    always_comb begin
        case (ctrl_r.mini_mode)
            `HMC_MINI_SAME: mini_src = full_src;
            `HMC_MINI_FREEZE: mini_src = hmc_pkg::HMC_SRC_FROZEN;
            `HMC_MINI_FAST: mini_src = hmc_pkg::HMC_SRC_FAST;
            `HMC_MINI_SLOW: mini_src = hmc_pkg::HMC_SRC_SLOW;
            default: mini_src = full_src;
        endcase
    end
    // Full holdover takes precedence if both flags are raised at once
    wire hmc_pkg::hmc_src_t src_nxt = i_full_holdover ? full_src
                                    : i_mini_holdover ? mini_src
                                    : hmc_pkg::HMC_SRC_TRACK;

    // On the entry cycle the frozen register is still loading, so bypass it
    wire [18:0] frozen_word = hold_entry ? i_dpll_freq : frozen_q;

    logic [18:0] freq_nxt;
    always_comb begin
        case (src_nxt)
            hmc_pkg::HMC_SRC_MANUAL: freq_nxt = manual_word;
            hmc_pkg::HMC_SRC_FROZEN: freq_nxt = frozen_word;
            hmc_pkg::HMC_SRC_FAST: freq_nxt = i_avg.fast;
            hmc_pkg::HMC_SRC_SLOW: freq_nxt = i_avg.slow;
            default: freq_nxt = i_dpll_freq;
        endcase
    end

    hmc_word_hold #(
        .W(`HMC_FREQ_W)
    ) u_frozen (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_load(hold_entry),
        .i_d(i_dpll_freq),
        .o_q(frozen_q)
    );

    // Bits 2:0 read back through the same source choice as the lower bytes
    wire [7:0] rdata_nxt = ctrl_rd ? {ctrl_r.auto_avg, ctrl_r.fast_avg, ctrl_r.read_avg,
                                      ctrl_r.mini_mode, readback_nxt[18:16]} : 8'h00;

    // ------------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_hold_d_r <= 1'b0;
            o_freq_src <= hmc_pkg::HMC_SRC_TRACK;
            o_holdover_freq <= 19'h00000;
            o_freq_readback <= 19'h00000;
            o_fast_sel <= 1'b0;
            o_in_holdover <= 1'b0;
            o_reg_rdata <= 8'h00;
        end else begin
            in_hold_d_r <= in_hold;
            o_freq_src <= src_nxt;
            o_holdover_freq <= freq_nxt;
            o_freq_readback <= readback_nxt;
            o_fast_sel <= ctrl_r.fast_avg;
            o_in_holdover <= in_hold;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_ctrl_write;
        i_reg_wr && ctrl_hit;
    endsequence

    sequence s_ctrl_read;
        i_reg_rd && ctrl_hit && !i_reg_wr;
    endsequence

    property p_no_avg_when_off;
        i_full_holdover && !i_manual_holdover && !ctrl_r.auto_avg
            |=> o_freq_src == hmc_pkg::HMC_SRC_FROZEN;
    endproperty
    a_no_avg_when_off: assert property (p_no_avg_when_off)
        else $error("averaging disabled but holdover did not freeze");

    property p_avg_when_on;
        i_full_holdover && !i_manual_holdover && ctrl_r.auto_avg && ctrl_r.fast_avg
            |=> o_freq_src == hmc_pkg::HMC_SRC_FAST && o_holdover_freq == $past(i_avg.fast);
    endproperty
    a_avg_when_on: assert property (p_avg_when_on)
        else $error("averaging enabled but averaged frequency not used");

    property p_manual_wins;
        i_full_holdover && i_manual_holdover
            |=> o_freq_src == hmc_pkg::HMC_SRC_MANUAL;
    endproperty
    a_manual_wins: assert property (p_manual_wins)
        else $error("manual holdover did not take priority");

    property p_rate_follows_write;
        s_ctrl_write |-> ##2 o_fast_sel == $past(i_reg_wdata[`HMC_BIT_FAST_AVG], 2);
    endproperty
    a_rate_follows_write: assert property (p_rate_follows_write)
        else $error("rate select output did not follow the written bit");

    property p_readback_written;
        !ctrl_r.read_avg |=> o_freq_readback == $past(manual_word);
    endproperty
    a_readback_written: assert property (p_readback_written)
        else $error("readback did not return the written word");

    property p_readback_avg;
        ctrl_r.read_avg && !ctrl_r.fast_avg |=> o_freq_readback == $past(i_avg.slow);
    endproperty
    a_readback_avg: assert property (p_readback_avg)
        else $error("readback did not return the slow averager output");

    property p_mini_policy;
        i_mini_holdover && !i_full_holdover && ctrl_r.mini_mode == `HMC_MINI_FREEZE
            |=> o_freq_src == hmc_pkg::HMC_SRC_FROZEN && o_in_holdover;
    endproperty
    a_mini_policy: assert property (p_mini_policy)
        else $error("brief loss freeze policy not applied");

    property p_ctrl_roundtrip;
        s_ctrl_write ##1 s_ctrl_read
            |=> o_reg_rdata[7:3] == $past(i_reg_wdata[7:3], 2);
    endproperty
    a_ctrl_roundtrip: assert property (p_ctrl_roundtrip)
        else $error("control register did not read back its written value");

    property p_freq_hi;
        i_full_holdover && i_manual_holdover
            |=> o_holdover_freq[18:16] == $past(ctrl_r.freq_hi);
    endproperty
    a_freq_hi: assert property (p_freq_hi)
        else $error("manual word upper bits not taken from control register");

endmodule

// [hmc_holdover_mode_control_bench.sv]
// Self-checking bench for the holdover mode control block
`timescale 1ns/10ps
module hmc_holdover_mode_control_bench;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic [7:0] o_reg_rdata;
    logic [15:0] i_freq_low = 16'h1234;
    logic [18:0] i_dpll_freq = 19'h13579;
    hmc_pkg::hmc_avg_t i_avg = {19'h6abcd, 19'h2f00d};
    logic i_manual_holdover = 1'b0;
    logic i_full_holdover = 1'b0;
    logic i_mini_holdover = 1'b0;
    hmc_pkg::hmc_src_t o_freq_src;
    logic [18:0] o_holdover_freq;
    logic [18:0] o_freq_readback;
    logic o_fast_sel;
    logic o_in_holdover;
    int miscompares = 0;
    int num_checks = 0;

    always #2.5 i_clk_sys = ~i_clk_sys;

    hmc_holdover_mode_control uut (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .i_freq_low(i_freq_low),
        .i_dpll_freq(i_dpll_freq),
        .i_avg(i_avg),
        .i_manual_holdover(i_manual_holdover),
        .i_full_holdover(i_full_holdover),
        .i_mini_holdover(i_mini_holdover),
        .o_freq_src(o_freq_src),
        .o_holdover_freq(o_holdover_freq),
        .o_freq_readback(o_freq_readback),
        .o_fast_sel(o_fast_sel),
        .o_in_holdover(o_in_holdover)
    );

    // ------------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------------
    // Inputs always move 1 ns after the rising edge, so no race with the design
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            #1;
        end
    endtask

    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_reg_addr = addr;
        i_reg_wdata = data;
        i_reg_wr = 1'b1;
        tick(1);
        i_reg_wr = 1'b0;
    endtask

    // Read data is registered at the strobe edge, so it is settled right after
    // An idle edge follows, so back-to-back reads never retoggle the strobe in one step
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        i_reg_addr = addr;
        i_reg_rd = 1'b1;
        tick(1);
        i_reg_rd = 1'b0;
        chk({11'h000, o_reg_rdata}, {11'h000, exp});
        tick(1);
    endtask

    // Leave holdover first so that every case sees a fresh entry and a fresh freeze
    task automatic hcase(input logic [7:0] c, input logic f, input logic m, input logic mn,
                         input hmc_pkg::hmc_src_t s, input logic [18:0] q);
        wr(8'h40, c);
        i_full_holdover = 1'b0;
        i_mini_holdover = 1'b0;
        i_manual_holdover = mn;
        i_dpll_freq = 19'h13579;
        tick(2);
        i_full_holdover = f;
        i_mini_holdover = m;
        tick(3);
        chk({16'h0000, o_freq_src}, {16'h0000, s});
        chk(o_holdover_freq, q);
        chk({18'h00000, o_in_holdover}, 19'h00001);
        // A moving live word must not disturb a held source
        i_dpll_freq = 19'h02468;
        tick(2);
        chk(o_holdover_freq, q);
        i_full_holdover = 1'b0;
        i_mini_holdover = 1'b0;
        i_manual_holdover = 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        tick(2);
        chk({16'h0000, o_freq_src}, {16'h0000, hmc_pkg::HMC_SRC_TRACK});
        chk(o_holdover_freq, 19'h13579);
        chk({18'h00000, o_fast_sel}, 19'h00000);
        chk({18'h00000, o_in_holdover}, 19'h00000);
        rd(8'h40, 8'h88);
        wr(8'h3f, 8'hff);
        rd(8'h40, 8'h88);
        rd(8'h3f, 8'h00);
        wr(8'h40, 8'h45);
        rd(8'h40, 8'h45);
        chk({18'h00000, o_fast_sel}, 19'h00001);
        chk(o_freq_readback, 19'h51234);
        wr(8'h40, 8'h65);
        rd(8'h40, 8'h66);
        chk(o_freq_readback, 19'h6abcd);
        wr(8'h40, 8'h25);
        rd(8'h40, 8'h22);
        chk(o_freq_readback, 19'h2f00d);
        chk({18'h00000, o_fast_sel}, 19'h00000);
        // Full holdover: manual first, then the averager, then the freeze
        hcase(8'hc5, 1'b1, 1'b0, 1'b1, hmc_pkg::HMC_SRC_MANUAL, 19'h51234);
        hcase(8'hc5, 1'b1, 1'b0, 1'b0, hmc_pkg::HMC_SRC_FAST, 19'h6abcd);
        hcase(8'h85, 1'b1, 1'b0, 1'b0, hmc_pkg::HMC_SRC_SLOW, 19'h2f00d);
        hcase(8'h05, 1'b1, 1'b0, 1'b0, hmc_pkg::HMC_SRC_FROZEN, 19'h13579);
        hcase(8'h05, 1'b1, 1'b0, 1'b1, hmc_pkg::HMC_SRC_MANUAL, 19'h51234);
        // Brief input loss, every policy code
        hcase(8'h85, 1'b0, 1'b1, 1'b0, hmc_pkg::HMC_SRC_SLOW, 19'h2f00d);
        hcase(8'h05, 1'b0, 1'b1, 1'b0, hmc_pkg::HMC_SRC_FROZEN, 19'h13579);
        hcase(8'hcd, 1'b0, 1'b1, 1'b0, hmc_pkg::HMC_SRC_FROZEN, 19'h13579);
        hcase(8'h95, 1'b0, 1'b1, 1'b0, hmc_pkg::HMC_SRC_FAST, 19'h6abcd);
        hcase(8'hdd, 1'b0, 1'b1, 1'b0, hmc_pkg::HMC_SRC_SLOW, 19'h2f00d);
        hcase(8'hcd, 1'b1, 1'b1, 1'b0, hmc_pkg::HMC_SRC_FAST, 19'h6abcd);
        close_out();
    end
endmodule

// [hmc_params.svh]
// Constants of the holdover mode control block: offsets, fields, reset values, widths
`ifndef HMC_PARAMS_SVH
`define HMC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define HMC_ADDR_HOLD_CTRL 8'h40
`define HMC_CTRL_RST 8'h88

// ----------------------------------------------------------------------------
// Field positions in the control register
// ----------------------------------------------------------------------------
`define HMC_BIT_AUTO_AVG 7
`define HMC_BIT_FAST_AVG 6
`define HMC_BIT_READ_AVG 5
`define HMC_BIT_MINI_HI 4
`define HMC_BIT_MINI_LO 3
`define HMC_BIT_FHI_HI 2
`define HMC_BIT_FHI_LO 0

// ----------------------------------------------------------------------------
// Brief-loss policy encodings
// ----------------------------------------------------------------------------
`define HMC_MINI_SAME 2'h0
`define HMC_MINI_FREEZE 2'h1
`define HMC_MINI_FAST 2'h2
`define HMC_MINI_SLOW 2'h3

// ----------------------------------------------------------------------------
// Frequency word widths
// ----------------------------------------------------------------------------
`define HMC_FREQ_W 19
`define HMC_FREQ_LO_W 16

`endif

// [hmc_pkg.sv]
// Types shared by the holdover mode control block
package hmc_pkg;

    // ------------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic auto_avg;
        logic fast_avg;
        logic read_avg;
        logic [1:0] mini_mode;
        logic [2:0] freq_hi;
    } hmc_ctrl_t;

    // ------------------------------------------------------------------------
    // Frequency source handed to the primary digital PLL
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        HMC_SRC_TRACK,
        HMC_SRC_MANUAL,
        HMC_SRC_FROZEN,
        HMC_SRC_FAST,
        HMC_SRC_SLOW
    } hmc_src_t;

    // ------------------------------------------------------------------------
    // Averager outputs travel together
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [18:0] fast;
        logic [18:0] slow;
    } hmc_avg_t;

endpackage

// [hmc_word_hold.sv]
// Loadable word register used to freeze the frequency at holdover entry
`timescale 1ns/10ps
module hmc_word_hold #(
    parameter int W = 19
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    if (W < 1) begin
        $error("hmc_word_hold: W must be at least 1");
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= '0;
        end else if (i_load) begin
            o_q <= i_d;
        end
    end

endmodule
